// ### hw/sep_core.sv
// Serial EEPROM command port: frame decoder, array, programming engine, APB
`timescale 1ns/100ps
`default_nettype none
module sep_core
    import sep_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = sep_pkg::PROG_CYCLES_DEF
) (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_rst,
    input  wire logic                        i_select,
    input  wire logic                        i_serial_clock_in,
    input  wire logic                        i_serial_in,
    input  wire logic                        i_word_width_strap,
    output logic                             o_serial_out,
    output logic                             o_serial_out_oe,
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [sep_pkg::APB_AW-1:0]  i_paddr,
    input  wire logic [31:0]                 i_pwdata,
    output logic      [31:0]                 o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr
);
    import sep_pkg::*;

    localparam int unsigned TW = $clog2(PROG_CYCLES + 1);

    // Pin synchronisation and edge detection
    logic [3:0] pins_s;
    logic       sel_s, sk_s, di_s, strap_s;
    logic       sel_d_q, sk_d_q;
    logic       sel_rise, sk_rise;

    sep_sync #(.W(4)) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_d        ({i_select, i_serial_clock_in, i_serial_in, i_word_width_strap}),
        .o_q        (pins_s)
    );

    assign {sel_s, sk_s, di_s, strap_s} = pins_s;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sel_d_q <= 1'b0;
            sk_d_q  <= 1'b0;
        end else begin
            sel_d_q <= sel_s;
            sk_d_q  <= sk_s;
        end
    end

    assign sel_rise = sel_s & ~sel_d_q;
    // A clock edge in the select rising cycle is dropped with the reset
    assign sk_rise  = sk_s & ~sk_d_q & sel_s & ~sel_rise;

    // Frame state
    sep_state_e         st_q;
    logic [4:0]         cnt_q;
    logic [1:0]         op_q;
    logic [ADDR_W-1:0]  addr_q;
    logic [WORD_W-1:0]  data_q;
    logic               wide_q;
    logic               prog_en_q;
    logic               busy_q;
    logic               wp_q;

    logic [ADDR_W-1:0]  addr_nx;
    logic [WORD_W-1:0]  data_nx;
    logic [4:0]         alen, dlen;
    logic               last_addr, last_data;
    logic [1:0]         ext_nx;
    logic               allow;
    logic               launch, launch_all, read_go;
    logic               cmd_en, cmd_dis;
    logic [ADDR_W-1:0]  launch_addr;
    logic [WORD_W-1:0]  launch_data;

    assign addr_nx = {addr_q[ADDR_W-2:0], di_s};
    assign data_nx = {data_q[WORD_W-2:0], di_s};
    assign alen    = wide_q ? 5'(ADDR_LEN_16) : 5'(ADDR_LEN_8);
    assign dlen    = wide_q ? 5'(DATA_LEN_16) : 5'(DATA_LEN_8);
    assign ext_nx  = wide_q ? addr_nx[ADDR_LEN_16-1 -: 2] : addr_nx[ADDR_LEN_8-1 -: 2];
    assign last_addr = sk_rise & (st_q == SEP_ST_ADDR) & (cnt_q == alen - 5'd1);
    assign last_data = sk_rise & (st_q == SEP_ST_DATA) & (cnt_q == dlen - 5'd1);
    // Programming is refused while disabled, busy or write-protected by software
    assign allow   = prog_en_q & ~busy_q & ~wp_q;

    always_comb begin
        launch       = 1'b0;
        launch_all   = 1'b0;
        read_go      = 1'b0;
        cmd_en       = 1'b0;
        cmd_dis      = 1'b0;
        launch_addr  = addr_q;
        launch_data  = ERASED_WORD;
        if (last_addr) begin
            launch_addr = addr_nx;
            case (sep_op_e'(op_q))
                SEP_OP_READ:  read_go = ~busy_q;
                SEP_OP_ERASE: launch = allow;
                SEP_OP_EXT: begin
                    cmd_en     = (ext_nx == SEP_EXT_ENABLE) & ~busy_q;
                    cmd_dis    = (ext_nx == SEP_EXT_DISABLE) & ~busy_q;
                    launch     = allow & (ext_nx == SEP_EXT_ERASE_ALL);
                    launch_all = 1'b1;
                end
                default:      launch = 1'b0;
            endcase
        end else if (last_data) begin
            launch      = allow;
            launch_all  = (sep_op_e'(op_q) == SEP_OP_EXT);
            launch_data = wide_q ? data_nx : {data_nx[7:0], data_nx[7:0]};
        end
    end

    // Command frame decoder; select low or rising clears it
    always_ff @(posedge i_core_clk) begin
        if (i_rst || sel_rise || !sel_s) begin
            st_q   <= SEP_ST_IDLE;
            cnt_q  <= 5'd0;
            op_q   <= 2'b00;
            addr_q <= '0;
            data_q <= '0;
            wide_q <= 1'b1;
        end else if (sk_rise) begin
            case (st_q)
                SEP_ST_IDLE, SEP_ST_DONE: begin
                    if (di_s && (st_q == SEP_ST_IDLE || !busy_q)) begin
                        st_q   <= SEP_ST_OPC;
                        cnt_q  <= 5'd0;
                        wide_q <= strap_s;
                    end
                end
                SEP_ST_OPC: begin
                    op_q  <= {op_q[0], di_s};
                    cnt_q <= (cnt_q == 5'd1) ? 5'd0 : cnt_q + 5'd1;
                    if (cnt_q == 5'd1) begin
                        st_q <= SEP_ST_ADDR;
                    end
                end
                SEP_ST_ADDR: begin
                    addr_q <= addr_nx;
                    cnt_q  <= cnt_q + 5'd1;
                    if (last_addr) begin
                        cnt_q <= 5'd0;
                        if (sep_op_e'(op_q) == SEP_OP_WRITE ||
                            (sep_op_e'(op_q) == SEP_OP_EXT && ext_nx == SEP_EXT_WRITE_ALL)) begin
                            st_q <= SEP_ST_DATA;
                        end else if (read_go) begin
                            st_q <= SEP_ST_READ;
                        end else begin
                            st_q <= SEP_ST_DONE;
                        end
                    end
                end
                SEP_ST_DATA: begin
                    data_q <= data_nx;
                    cnt_q  <= cnt_q + 5'd1;
                    if (last_data) begin
                        st_q <= SEP_ST_DONE;
                    end
                end
                SEP_ST_READ: st_q <= SEP_ST_READ;
                default:     st_q <= SEP_ST_IDLE;
            endcase
        end
    end

    // Enable latch survives select; only the core reset stands for power loss
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            prog_en_q <= 1'b0;
        end else if (cmd_en) begin
            prog_en_q <= 1'b1;
        end else if (cmd_dis) begin
            prog_en_q <= 1'b0;
        end
    end

    // Array, split in byte halves so byte writes need no read-modify-write
    logic [7:0] mem_hi [ROWS];
    logic [7:0] mem_lo [ROWS];

    logic [TW-1:0]     timer_q;
    logic              walk_act_q;
    logic [ROW_W-1:0]  walk_q;
    logic              pg_all_q;
    logic [ROW_W-1:0]  pg_row_q;
    logic              pg_we_hi_q, pg_we_lo_q;
    logic [WORD_W-1:0] pg_data_q;
    logic [ROW_W-1:0]  wr_row;

    // Programming engine; runs on the core clock alone once launched
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            busy_q     <= 1'b0;
            timer_q    <= '0;
            walk_act_q <= 1'b0;
            walk_q     <= '0;
            pg_all_q   <= 1'b0;
            pg_row_q   <= '0;
            pg_we_hi_q <= 1'b0;
            pg_we_lo_q <= 1'b0;
            pg_data_q  <= '0;
        end else if (launch) begin
            busy_q     <= 1'b1;
            timer_q    <= TW'(PROG_CYCLES - 1);
            walk_act_q <= 1'b1;
            walk_q     <= '0;
            pg_all_q   <= launch_all;
            pg_row_q   <= wide_q ? launch_addr[ROW_W-1:0] : launch_addr[ROW_W:1];
            pg_we_hi_q <= launch_all | wide_q | ~launch_addr[0];
            pg_we_lo_q <= launch_all | wide_q | launch_addr[0];
            pg_data_q  <= launch_data;
        end else if (busy_q) begin
            if (timer_q != '0) begin
                timer_q <= timer_q - TW'(1);
            end
            if (walk_act_q) begin
                if (!pg_all_q || walk_q == ROW_W'(ROWS - 1)) begin
                    walk_act_q <= 1'b0;
                end
                walk_q <= walk_q + ROW_W'(1);
            end
            if (timer_q == '0 && !walk_act_q) begin
                busy_q <= 1'b0;
            end
        end
    end

    assign wr_row = pg_all_q ? walk_q : pg_row_q;

    always_ff @(posedge i_core_clk) begin
        if (walk_act_q) begin
            if (pg_we_hi_q) begin
                mem_hi[wr_row] <= pg_data_q[15:8];
            end
            if (pg_we_lo_q) begin
                mem_lo[wr_row] <= pg_data_q[7:0];
            end
        end
    end

    // Serial output path
    logic              show_stat_q;
    logic              rd_act_q;
    logic              rd_bit_q;
    logic [WORD_W-1:0] rd_sr_q;
    logic [ROW_W-1:0]  rd_row;
    logic [WORD_W-1:0] rd_word;

    assign rd_row  = wide_q ? addr_nx[ROW_W-1:0] : addr_nx[ROW_W:1];
    assign rd_word = wide_q ? {mem_hi[rd_row], mem_lo[rd_row]}
                            : {(addr_nx[0] ? mem_lo[rd_row] : mem_hi[rd_row]), 8'h00};

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            show_stat_q <= 1'b0;
        end else if (sel_rise) begin
            show_stat_q <= busy_q;
        end else if (launch) begin
            show_stat_q <= 1'b1;
        end else if (sk_rise && di_s && !busy_q) begin
            show_stat_q <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst || sel_rise || !sel_s) begin
            rd_act_q <= 1'b0;
            rd_bit_q <= 1'b0;
            rd_sr_q  <= '0;
        end else if (last_addr && read_go) begin
            rd_act_q <= 1'b1;
            rd_bit_q <= 1'b0;
            rd_sr_q  <= rd_word;
        end else if (sk_rise && rd_act_q) begin
            rd_bit_q <= rd_sr_q[WORD_W-1];
            rd_sr_q  <= {rd_sr_q[WORD_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_serial_out_oe <= 1'b0;
            o_serial_out    <= 1'b0;
        end else begin
            o_serial_out_oe <= sel_s & ~sel_rise & (show_stat_q | rd_act_q);
            o_serial_out    <= show_stat_q ? ~busy_q : rd_bit_q;
        end
    end

    // APB slave: one wait-free access phase, pslverr on unmapped addresses
    logic apb_setup;
    logic apb_done;

    assign apb_setup = i_psel & ~i_penable;
    assign apb_done  = i_psel & i_penable & o_pready;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= '0;
        end else begin
            o_pready  <= apb_setup;
            o_pslverr <= apb_setup & (i_paddr != REG_CTRL) & (i_paddr != REG_STATUS);
            o_prdata  <= '0;
            if (apb_setup && !i_pwrite) begin
                if (i_paddr == REG_CTRL) begin
                    o_prdata[CTRL_WP_BIT] <= wp_q;
                end else if (i_paddr == REG_STATUS) begin
                    o_prdata[STAT_BUSY_BIT] <= busy_q;
                    o_prdata[STAT_EN_BIT]   <= prog_en_q;
                    o_prdata[STAT_WIDE_BIT] <= strap_s;
                    o_prdata[STAT_WP_BIT]   <= wp_q;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wp_q <= 1'b0;
        end else if (apb_done && i_pwrite && i_paddr == REG_CTRL) begin
            wp_q <= i_pwdata[CTRL_WP_BIT];
        end
    end

endmodule : sep_core
`default_nettype wire

// ### hw/sep_pkg.sv
// Constants shared by the serial EEPROM command port
//
// Contract
// - Select low: interface ignored, serial output high impedance.
// - Rising select resets all command registers and enables the interface.
// - A started programming cycle always runs to completion.
// - Programming with select high: output low when busy, high when ready.
// - Select toggling during programming only samples status, never disturbs it.
// - Start bit after ready returns output to high impedance; may open command.
// - Falling select never starts programming; only the bit count does.
// - Input bits sampled and output advanced on serial clock rising edges.
// - Programming and busy/ready follow internal state, not the serial clock.
// - First 1 after select rises is the start bit; leading zeros ignored.
// - Read data starts shifting only after the address LSB is clocked in.
// - Strap high: 16-bit words, 10 address bits; low: 8-bit, 11 bits.
// - Start bit then opcode: 10 read, 01 write, 11 erase, 00 extended.
// - Extended top bits: 11 enable, 00 disable, 10 erase whole array.
// - Write carries address then one data word of strap width.
// - Extended 01 carries a data word written to every location.
// - A single dummy 0 precedes the read data word.
// - Powers up disabled; enable persists until disable or power loss.
// - Programming starts on final bit's clock edge; earlier select drop aborts.
// - Erase and erase-all set every targeted bit to 1.
package sep_pkg;

    localparam int unsigned ADDR_W     = 11;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned ADDR_LEN_16 = 10;
    localparam int unsigned ADDR_LEN_8  = 11;
    localparam int unsigned DATA_LEN_16 = 16;
    localparam int unsigned DATA_LEN_8  = 8;
    localparam int unsigned ROWS       = 1024;
    localparam int unsigned ROW_W      = 10;

    // Self-timed programming time
    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned T_PROG_US       = 10000;
    localparam int unsigned PROG_CYCLES_DEF = T_PROG_US * CLK_MHZ;

    typedef enum logic [1:0] {
        SEP_OP_EXT   = 2'b00,
        SEP_OP_WRITE = 2'b01,
        SEP_OP_READ  = 2'b10,
        SEP_OP_ERASE = 2'b11
    } sep_op_e;

    typedef enum logic [1:0] {
        SEP_EXT_DISABLE   = 2'b00,
        SEP_EXT_WRITE_ALL = 2'b01,
        SEP_EXT_ERASE_ALL = 2'b10,
        SEP_EXT_ENABLE    = 2'b11
    } sep_ext_e;

    typedef enum logic [2:0] {
        SEP_ST_IDLE = 3'b000,
        SEP_ST_OPC  = 3'b001,
        SEP_ST_ADDR = 3'b010,
        SEP_ST_DATA = 3'b011,
        SEP_ST_READ = 3'b100,
        SEP_ST_DONE = 3'b101
    } sep_state_e;

    // APB register map
    localparam int unsigned APB_AW     = 12;
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam int unsigned CTRL_WP_BIT   = 0;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_EN_BIT   = 1;
    localparam int unsigned STAT_WIDE_BIT = 2;
    localparam int unsigned STAT_WP_BIT   = 3;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

endpackage : sep_pkg

// ### hw/sep_sync.sv
// Two-flop synchroniser for asynchronous input pins
`timescale 1ns/100ps
`default_nettype none
module sep_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule : sep_sync
`default_nettype wire

// ### sim/sep_core_chk.sv
// Concurrent checks on the command port pins and register bus
`timescale 1ns/100ps
`default_nettype none
module sep_core_chk
    import sep_pkg::*;
(
    input wire logic                       i_core_clk,
    input wire logic                       i_rst,
    input wire logic                       i_select,
    input wire logic                       i_psel,
    input wire logic                       i_penable,
    input wire logic [sep_pkg::APB_AW-1:0] i_paddr,
    input wire logic                       o_serial_out,
    input wire logic                       o_serial_out_oe,
    input wire logic [31:0]                o_prdata,
    input wire logic                       o_pready,
    input wire logic                       o_pslverr
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Synchroniser plus output register need a few cycles to let go of the pin
    sequence s_sel_idle;
        !i_select [*6];
    endsequence
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    a_sel_low_hiz: assert property (s_sel_idle |-> !o_serial_out_oe)
        else $error("serial output driven while select low");
    a_oe_needs_sel: assert property ($rose(o_serial_out_oe) |-> i_select)
        else $error("serial output enabled without select");
    a_oe_rise_low: assert property ($rose(o_serial_out_oe) |-> !o_serial_out)
        else $error("serial output not low when first driven");
    a_apb_answer: assert property (s_setup |=> o_pready)
        else $error("no ready in first access cycle");
    a_apb_in_access: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside an access cycle");
    a_apb_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    a_apb_decode: assert property (o_pready |->
        o_pslverr == (i_paddr != REG_CTRL && i_paddr != REG_STATUS))
        else $error("error response does not match address decode");
    a_apb_err_zero: assert property (o_pready && o_pslverr |-> o_prdata == 32'h0)
        else $error("read data not zero on error response");
endmodule : sep_core_chk
bind sep_core sep_core_chk i_sep_core_chk (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_select(i_select), .i_psel(i_psel),
    .i_penable(i_penable), .i_paddr(i_paddr), .o_serial_out(o_serial_out),
    .o_serial_out_oe(o_serial_out_oe), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr));
`default_nettype wire

// ### sim/sep_core_tb.sv
// Self-checking bench for the serial EEPROM command port
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module sep_core_tb;
    import sep_pkg::*;
    // Short programming time keeps the run brief
    localparam int unsigned PROG = 2000;
    logic              i_core_clk = 1'b0;
    logic              i_rst      = 1'b1;
    logic              strap;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready, pslverr, sdo, sdo_oe, sel, sclk, sdi;
    int                num_errors = 0;
    int                checks     = 0;
    always #5 i_core_clk = ~i_core_clk;
    sep_core #(.PROG_CYCLES(PROG)) i_sep_core (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_select(sel), .i_serial_clock_in(sclk),
        .i_serial_in(sdi), .i_word_width_strap(strap), .o_serial_out(sdo),
        .o_serial_out_oe(sdo_oe), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr));
    sep_host i_sep_host (.i_core_clk(i_core_clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
        .o_select(sel), .o_sclk(sclk), .o_sdi(sdi));
    task automatic print_verdict();
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    task automatic bail();
        `CHK("timeout", 1'b0, 1'b1)
        print_verdict();
    endtask : bail
    task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        k = 0;
        @(posedge i_core_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge i_core_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            k++;
            if (k > 20) bail();
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic stat(output logic [31:0] r);
        logic e;
        apb(1'b0, REG_STATUS, 32'h0, r, e);
    endtask : stat
    task automatic wait_idle();
        logic [31:0] r;
        for (int k = 0; k < PROG; k++) begin
            stat(r);
            if (r[STAT_BUSY_BIT] === 1'b0) return;
        end
        bail();
    endtask : wait_idle
    task automatic frame(input int n, input logic [31:0] v, output logic [31:0] g);
        i_sep_host.sel(1'b1);
        i_sep_host.xfer(n, v, g);
        i_sep_host.sel(1'b0);
    endtask : frame
    // Two leading zeros go ahead of every read
    task automatic rd(input logic [10:0] a, input logic [15:0] e);
        logic [31:0] g;
        if (strap) begin
            frame(32, {2'b00, 3'b110, a[9:0], 17'h0}, g);
            `CHK("read dummy", 1'b0, g[16])
            `CHK("read word", e, g[15:0])
        end else begin
            frame(25, {2'b00, 3'b110, a, 9'h0}, g);
            `CHK("read dummy", 1'b0, g[8])
            `CHK("read byte", e[7:0], g[7:0])
        end
    endtask : rd
    task automatic t_idle();
        logic [31:0] r, g;
        repeat (8) @(posedge i_core_clk);
        `CHK("oe idle", 1'b0, sdo_oe)
        stat(r);
        `CHK("status at reset", 2'b00, {r[STAT_EN_BIT], r[STAT_BUSY_BIT]})
        frame(13, {3'b100, SEP_EXT_ENABLE, 8'h0}, g);
        stat(r);
        `CHK("enable set", 1'b1, r[STAT_EN_BIT])
        frame(29, {3'b100, SEP_EXT_WRITE_ALL, 8'h0, 16'h1234}, g);
        wait_idle();
        rd(11'd5, 16'h1234);
    endtask : t_idle
    task automatic t_write();
        logic [31:0] g;
        int k;
        i_sep_host.sel(1'b1);
        i_sep_host.xfer(29, {3'b101, 10'd5, 16'hA5C3}, g);
        repeat (4) @(posedge i_core_clk);
        `CHK("busy shown", 2'b10, {sdo_oe, sdo})
        for (k = 0; k < PROG + 100 && sdo !== 1'b1; k++) @(posedge i_core_clk);
        `CHK("ready shown", 2'b11, {sdo_oe, sdo})
        `CHK("busy length", 1'b1, k > PROG - 20)
        if (sdo !== 1'b1) bail();
        i_sep_host.xfer(1, 1'b1, g);
        repeat (4) @(posedge i_core_clk);
        `CHK("start clears ready", 1'b0, sdo_oe)
        i_sep_host.sel(1'b0);
        rd(11'd5, 16'hA5C3);
        rd(11'd9, 16'h1234);
    endtask : t_write
    task automatic t_toggle();
        logic [31:0] g;
        i_sep_host.sel(1'b1);
        i_sep_host.xfer(13, {3'b111, 10'd5}, g);
        repeat (3) begin
            i_sep_host.sel(1'b0);
            `CHK("oe select low", 1'b0, sdo_oe)
            i_sep_host.sel(1'b1);
            `CHK("busy on reselect", 2'b10, {sdo_oe, sdo})
        end
        i_sep_host.xfer(29, {3'b101, 10'd9, 16'h0000}, g);
        i_sep_host.sel(1'b0);
        wait_idle();
        rd(11'd5, 16'hFFFF);
        rd(11'd9, 16'h1234);
    endtask : t_toggle
    task automatic t_abort();
        logic [31:0] r, g;
        frame(28, {3'b101, 10'd9, 15'h0787}, g);
        stat(r);
        `CHK("no launch on select fall", 1'b0, r[STAT_BUSY_BIT])
        rd(11'd9, 16'h1234);
    endtask : t_abort
    task automatic t_protect();
        logic [31:0] r, g;
        logic e;
        frame(13, {3'b100, SEP_EXT_DISABLE, 8'h0}, g);
        frame(29, {3'b101, 10'd9, 16'h5555}, g);
        stat(r);
        `CHK("disabled", 2'b00, {r[STAT_EN_BIT], r[STAT_BUSY_BIT]})
        frame(13, {3'b100, SEP_EXT_ENABLE, 8'h0}, g);
        apb(1'b1, REG_CTRL, 32'h1, r, e);
        frame(29, {3'b101, 10'd9, 16'h5555}, g);
        apb(1'b1, REG_STATUS, 32'h0, r, e);
        stat(r);
        `CHK("status protected", 4'b1110, r[3:0])
        apb(1'b1, REG_CTRL, 32'h0, r, e);
        apb(1'b0, REG_CTRL, 32'h0, r, e);
        `CHK("ctrl readback", 1'b0, r[CTRL_WP_BIT])
        apb(1'b0, 12'h010, 32'h0, r, e);
        `CHK("unmapped error", 33'h100000000, {e, r})
        rd(11'd9, 16'h1234);
    endtask : t_protect
    task automatic t_byte();
        logic [31:0] g;
        @(posedge i_core_clk);
        strap <= 1'b0;
        repeat (8) @(posedge i_core_clk);
        rd(11'd18, 16'h0012);
        rd(11'd19, 16'h0034);
        frame(22, {3'b101, 11'd19, 8'h5A}, g);
        wait_idle();
        rd(11'd19, 16'h005A);
        rd(11'd18, 16'h0012);
        strap <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        frame(13, {3'b100, SEP_EXT_ERASE_ALL, 8'h0}, g);
        wait_idle();
        rd(11'd9, 16'hFFFF);
    endtask : t_byte
    initial begin
        strap   <= 1'b1;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwrite  <= 1'b0;
        paddr   <= '0;
        pwdata  <= '0;
        repeat (4) @(posedge i_core_clk);
        i_rst <= 1'b0;
        t_idle();
        t_write();
        t_toggle();
        t_abort();
        t_protect();
        t_byte();
        print_verdict();
    end
endmodule : sep_core_tb
`default_nettype wire

// ### sim/sep_host.sv
// Host-side serial master model: select, serial clock and serial data
`timescale 1ns/100ps
`default_nettype none
module sep_host (
    input  wire logic i_core_clk,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe,
    output var logic  o_select,
    output var logic  o_sclk,
    output var logic  o_sdi
);
    // Half period of the 80 ns serial clock, in core cycles
    localparam int HALF = 4;
    wire logic line;
    // An undriven pin reads as high impedance, never as a stale level
    assign line = i_sdo_oe ? i_sdo : 1'bz;
    initial begin
        o_select = 1'b0;
        o_sclk   = 1'b0;
        o_sdi    = 1'b0;
    end
    task automatic sel(input logic v);
        @(posedge i_core_clk);
        o_select <= v;
        repeat (2 * HALF) @(posedge i_core_clk);
    endtask : sel
    // The pin is sampled just before each rise, so a sample shows the previous bit
    task automatic xfer(input int n, input logic [31:0] v, output logic [31:0] g);
        g = '0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge i_core_clk);
            o_sclk <= 1'b0;
            o_sdi  <= v[i];
            repeat (HALF - 1) @(posedge i_core_clk);
            @(posedge i_core_clk);
            g = {g[30:0], line};
            o_sclk <= 1'b1;
            repeat (HALF - 1) @(posedge i_core_clk);
        end
        @(posedge i_core_clk);
        o_sclk <= 1'b0;
        o_sdi  <= 1'b0;
    endtask : xfer
endmodule : sep_host
`default_nettype wire
